// *** cic_pkg.sv ***
package cic_pkg;

    // ------------------------------------------------------------
    // i/o addresses seen on the cpu side
    // ------------------------------------------------------------
    localparam logic [7:0] prim_even_addr = 8'h20;  // init word one, op commands two/three
    localparam logic [7:0] prim_odd_addr  = 8'h21;  // vector base, link, options, mask
    localparam logic [7:0] sec_even_addr  = 8'ha0;
    localparam logic [7:0] sec_odd_addr   = 8'ha1;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int init_flag_bit   = 4;             // marks init word one at even address
    localparam int level_trig_bit  = 3;             // level_trigger_select
    localparam int single_bit      = 1;             // 1 = single, 0 = cascade
    localparam int base_lsb        = 3;             // vector base in bits 7:3
    localparam int auto_done_bit   = 1;             // auto_service_done in options word
    localparam int cmd_sel_lsb     = 5;             // op command two selector, bits 7:5
    localparam int cmd_three_bit   = 3;             // set for op command three
    localparam logic [2:0] cmd_nonspec_done = 3'h1; // non-specific service_done_command
    localparam logic [2:0] spurious_index   = 3'h7; // request_line_seven
    localparam logic [2:0] cascade_input    = 3'h2; // request_line_two

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] mask_reset = 8'h00;
    localparam logic [4:0] base_reset = 5'h00;

    // ------------------------------------------------------------
    // host command registers
    // ------------------------------------------------------------
    localparam logic [2:0] host_io_addr_off = 3'h0; // i/o address for next write
    localparam logic [2:0] host_io_data_off = 3'h1; // write issues the i/o write
    localparam logic [2:0] host_ack_off     = 3'h2; // write starts an acknowledge pair
    localparam logic [2:0] host_status_off  = 3'h3; // {busy, vector_seen, int}
    localparam logic [2:0] host_vector_off  = 3'h4; // last vector taken

    // init sequence of one controller
    typedef enum logic [1:0] {
        cic_seq_ready,
        cic_seq_base,
        cic_seq_link,
        cic_seq_opts
    } cic_seq_t;

    // host acknowledge sequence
    typedef enum logic [1:0] {
        cic_ack_idle,
        cic_ack_first,
        cic_ack_gap,
        cic_ack_second
    } cic_ack_t;

endpackage

// *** cic_if.sv ***
`timescale 1ns/1ns
interface cic_if;
    logic [7:0] io_addr;       // i/o address of a write
    logic [7:0] io_data;       // i/o write data
    logic       io_wr;         // one-cycle i/o write strobe
    logic       ack_cycle;     // one-cycle pulse per acknowledge cycle
    logic       cpu_int;       // interrupt request to the cpu
    logic [7:0] vector;        // vector after the second acknowledge
    logic       vector_valid;  // one-cycle pulse with vector

    modport dev (
        input  io_addr,
        input  io_data,
        input  io_wr,
        input  ack_cycle,
        output cpu_int,
        output vector,
        output vector_valid
    );

    modport cpu (
        output io_addr,
        output io_data,
        output io_wr,
        output ack_cycle,
        input  cpu_int,
        input  vector,
        input  vector_valid
    );
endinterface

// *** cic_dev_end.sv ***
`timescale 1ns/1ns
// What this block does
// - software sets bit 4 in init word one
// - level mode: high request line raises request
// - level source drops line before service done
// - edge mode: only rising edge raises request
// - early drop yields request line seven vector
// - bit 1 picks single or cascade
// - secondary on input two supplies vector
// - software programs both controllers for cascade
// - vector base bits 7:3 kept per controller
// - low vector bits from resolver winner
// - customary bases are 08h and 70h
// - vector base word taken at odd addresses
// - primary link word 04h marks input two
// - secondary answers at its link identity
// - init word one clears the mask
// - auto service done after second acknowledge
module cic_dev_end (
    input  wire logic       clk_in,           // system clock
    input  wire logic       rst_in,           // async reset, active high
    cic_if.dev              bus,              // cpu side
    input  wire logic [7:0] req_primary_in,   // primary request lines
    input  wire logic [7:0] req_secondary_in, // secondary request lines
    output logic            cascade_mode_out  // primary set for cascade
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // winner: valid flag and index of best pending request, fully nested
    function automatic logic [3:0] pick(input logic [7:0] irr, input logic [7:0] request_mask_register,
                                        input logic [7:0] isr);
        logic [3:0] res;
        logic       blocked;
        res     = 4'h0;
        blocked = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (isr[i]) begin
                blocked = 1'b1;                   // equal and lower priorities wait
            end
            if (!blocked && !res[3] && irr[i] && !request_mask_register[i]) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction

    // one-hot of the highest-priority in-service bit
    function automatic logic [7:0] top_bit(input logic [7:0] isr);
        logic [7:0] res;
        res = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            if (isr[i]) begin
                res = 8'(1) << i;
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // per-controller state, index 0 primary, 1 secondary
    // ------------------------------------------------------------
    logic [7:0] irr_reg  [2];       // request latch
    logic [7:0] isr_reg  [2];       // in service
    logic [7:0] imr_reg  [2];       // request_mask_register
    logic [7:0] prev_reg [2];       // last sampled lines, for edges
    logic [7:0] link_reg [2];       // cascade_link_word
    logic [4:0] base_reg [2];       // vector base
    logic [2:0] lo_reg   [2];       // index frozen at first acknowledge
    logic       ltim_reg   [2];     // level_trigger_select
    logic       single_reg [2];     // single mode
    logic       auto_service_done_reg   [2];     // auto_service_done
    logic       ack_phase_reg;      // 0 waits first, 1 waits second
    logic       sec_sel_reg;        // secondary supplies the vector
    logic       int_reg;
    logic [7:0] vector_reg;
    logic       vector_valid_reg;

    // decoded i/o writes
    logic [1:0] wr_even;            // even address write per controller
    logic [1:0] wr_odd;             // odd address write per controller
    logic [7:0] line [2];           // effective request lines
    logic [3:0] win  [2];           // resolver output
    logic [2:0] idx  [2];           // index used in acknowledge
    logic       casc_hit;           // primary winner is a secondary input
    logic       sec_hit;            // secondary owns this acknowledge
    logic [1:0] take;               // controller joins first acknowledge
    logic [1:0] auto_clr;           // auto service done at second acknowledge

    // ------------------------------------------------------------
    // combinational decode
    // ------------------------------------------------------------
    always_comb begin
        wr_even[0] = bus.io_wr && (bus.io_addr == cic_pkg::prim_even_addr);
        wr_odd[0]  = bus.io_wr && (bus.io_addr == cic_pkg::prim_odd_addr);
        wr_even[1] = bus.io_wr && (bus.io_addr == cic_pkg::sec_even_addr);
        wr_odd[1]  = bus.io_wr && (bus.io_addr == cic_pkg::sec_odd_addr);
    end

    always_comb begin
        win[1]  = pick(irr_reg[1], imr_reg[1], isr_reg[1]);
        win[0]  = pick(irr_reg[0], imr_reg[0], isr_reg[0]);
        line[1] = req_secondary_in;
        line[0] = req_primary_in;
        // cascade ties the secondary's request onto input two
        if (!single_reg[0]) begin
            line[0][cic_pkg::cascade_input] = win[1][3];
        end
        // a winner that vanished before acknowledge reads as line seven
        idx[0]   = win[0][3] ? win[0][2:0] : cic_pkg::spurious_index;
        idx[1]   = win[1][3] ? win[1][2:0] : cic_pkg::spurious_index;
        casc_hit = !single_reg[0] && link_reg[0][idx[0]];
        sec_hit  = casc_hit && (link_reg[1][2:0] == idx[0]);
        take[0]  = bus.ack_cycle && !ack_phase_reg;
        take[1]  = take[0] && sec_hit;
        auto_clr[0] = bus.ack_cycle && ack_phase_reg && auto_service_done_reg[0];
        auto_clr[1] = bus.ack_cycle && ack_phase_reg && auto_service_done_reg[1] && sec_sel_reg;
    end

    // ------------------------------------------------------------
    // controller slices
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_ctl
        logic       init_control_word_one_wr;            // init word one seen
        logic       eoi_cmd;            // non-specific service done command
        cic_pkg::cic_seq_t seq_reg;     // init word position

        assign init_control_word_one_wr = wr_even[c] && bus.io_data[cic_pkg::init_flag_bit];
        assign eoi_cmd = wr_even[c] && !bus.io_data[cic_pkg::init_flag_bit]
                         && !bus.io_data[cic_pkg::cmd_three_bit]
                         && (bus.io_data[7:cic_pkg::cmd_sel_lsb] == cic_pkg::cmd_nonspec_done);

        // init sequence; later odd writes go to the mask
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                seq_reg       <= cic_pkg::cic_seq_ready;
                ltim_reg[c]   <= 1'b0;
                single_reg[c] <= 1'b0;
                auto_service_done_reg[c]   <= 1'b0;
                base_reg[c]   <= cic_pkg::base_reset;
                link_reg[c]   <= 8'h00;
                imr_reg[c]    <= cic_pkg::mask_reset;
            end else if (init_control_word_one_wr) begin
                seq_reg       <= cic_pkg::cic_seq_base;
                ltim_reg[c]   <= bus.io_data[cic_pkg::level_trig_bit];
                single_reg[c] <= bus.io_data[cic_pkg::single_bit];
                imr_reg[c]    <= cic_pkg::mask_reset;
            end else if (wr_odd[c]) begin
                unique case (seq_reg)
                    cic_pkg::cic_seq_base: begin
                        base_reg[c] <= bus.io_data[7:cic_pkg::base_lsb];
                        seq_reg     <= single_reg[c] ? cic_pkg::cic_seq_opts
                                                     : cic_pkg::cic_seq_link;
                    end
                    cic_pkg::cic_seq_link: begin
                        link_reg[c] <= bus.io_data;
                        seq_reg     <= cic_pkg::cic_seq_opts;
                    end
                    cic_pkg::cic_seq_opts: begin
                        auto_service_done_reg[c] <= bus.io_data[cic_pkg::auto_done_bit];
                        seq_reg     <= cic_pkg::cic_seq_ready;
                    end
                    cic_pkg::cic_seq_ready: begin
                        imr_reg[c]  <= bus.io_data;
                    end
                endcase
            end
        end

        // request latch: a line that falls drops its request
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                irr_reg[c]  <= 8'h00;
                prev_reg[c] <= 8'h00;
            end else begin
                prev_reg[c] <= line[c];
                if (init_control_word_one_wr) begin
                    irr_reg[c] <= 8'h00;
                end else if (ltim_reg[c]) begin
                    irr_reg[c] <= line[c];
                end else begin
                    // new edge wins over the acknowledge clear
                    irr_reg[c] <= ((irr_reg[c] & ~(take[c] ? (8'(1) << idx[c]) : 8'h00))
                                  | (line[c] & ~prev_reg[c])) & line[c];
                end
            end
        end

        // in-service bits and frozen index
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                isr_reg[c] <= 8'h00;
                lo_reg[c]  <= 3'h0;
            end else if (init_control_word_one_wr) begin
                isr_reg[c] <= 8'h00;
            end else if (take[c]) begin
                lo_reg[c]  <= idx[c];
                if (win[c][3]) begin
                    isr_reg[c] <= isr_reg[c] | (8'(1) << idx[c]);
                end
            end else if (auto_clr[c] || eoi_cmd) begin
                isr_reg[c] <= isr_reg[c] & ~top_bit(isr_reg[c]);
            end
        end
    end

    // ------------------------------------------------------------
    // acknowledge pair and vector
    // ------------------------------------------------------------
    // first pulse freezes the winner, second one drives the vector
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_phase_reg    <= 1'b0;
            sec_sel_reg      <= 1'b0;
            vector_reg       <= 8'h00;
            vector_valid_reg <= 1'b0;
        end else begin
            vector_valid_reg <= 1'b0;
            if (bus.ack_cycle && !ack_phase_reg) begin
                ack_phase_reg <= 1'b1;
                sec_sel_reg   <= sec_hit;
            end else if (bus.ack_cycle) begin
                ack_phase_reg    <= 1'b0;
                vector_valid_reg <= 1'b1;
                vector_reg       <= sec_sel_reg ? {base_reg[1], lo_reg[1]}
                                                : {base_reg[0], lo_reg[0]};
            end
        end
    end

    // interrupt line and mode flag
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            int_reg          <= 1'b0;
            cascade_mode_out <= 1'b0;
        end else begin
            int_reg          <= win[0][3];
            cascade_mode_out <= !single_reg[0];
        end
    end

    assign bus.cpu_int      = int_reg;
    assign bus.vector       = vector_reg;
    assign bus.vector_valid = vector_valid_reg;

endmodule // cic_dev_end

// *** cic_cpu_end.sv ***
`timescale 1ns/1ns
module cic_cpu_end (
    input  wire logic       clk_in,        // system clock
    input  wire logic       rst_in,        // async reset, active high
    cic_if.cpu              bus,           // controller side
    input  wire logic [2:0] reg_addr_in,   // command register index
    input  wire logic [7:0] reg_wdata_in,  // write data
    input  wire logic       reg_wr_in,     // write strobe
    input  wire logic       reg_rd_in,     // read strobe
    output logic      [7:0] reg_rdata_out  // read data, cycle after strobe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]        addr_reg;        // i/o address for writes
    logic [7:0]        io_addr_reg;
    logic [7:0]        io_data_reg;
    logic              io_wr_reg;
    logic              ack_reg;
    logic [7:0]        vec_reg;         // last vector taken
    logic              seen_reg;        // vector arrived since last start
    cic_pkg::cic_ack_t ack_st_reg;

    // i/o write: one cycle strobe with latched address
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg    <= 8'h00;
            io_addr_reg <= 8'h00;
            io_data_reg <= 8'h00;
            io_wr_reg   <= 1'b0;
        end else begin
            io_wr_reg <= 1'b0;
            if (reg_wr_in && reg_addr_in == cic_pkg::host_io_addr_off) begin
                addr_reg <= reg_wdata_in;
            end
            // software keeps bit 4 set for init word one
            if (reg_wr_in && reg_addr_in == cic_pkg::host_io_data_off) begin
                io_addr_reg <= addr_reg;
                io_data_reg <= reg_wdata_in;
                io_wr_reg   <= 1'b1;
            end
        end
    end

    // acknowledge pair with one idle cycle between pulses
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_st_reg <= cic_pkg::cic_ack_idle;
            ack_reg    <= 1'b0;
        end else begin
            ack_reg <= 1'b0;
            unique case (ack_st_reg)
                cic_pkg::cic_ack_idle: begin
                    if (reg_wr_in && reg_addr_in == cic_pkg::host_ack_off) begin
                        ack_st_reg <= cic_pkg::cic_ack_first;
                        ack_reg    <= 1'b1;
                    end
                end
                cic_pkg::cic_ack_first: ack_st_reg <= cic_pkg::cic_ack_gap;
                cic_pkg::cic_ack_gap: begin
                    ack_st_reg <= cic_pkg::cic_ack_second;
                    ack_reg    <= 1'b1;
                end
                cic_pkg::cic_ack_second: begin
                    if (bus.vector_valid) begin
                        ack_st_reg <= cic_pkg::cic_ack_idle;
                    end
                end
            endcase
        end
    end

    // vector capture and readback
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            vec_reg       <= 8'h00;
            seen_reg      <= 1'b0;
            reg_rdata_out <= 8'h00;
        end else begin
            if (bus.vector_valid) begin
                vec_reg  <= bus.vector;
                seen_reg <= 1'b1;                // set wins over a same-cycle start
            end else if (reg_wr_in && reg_addr_in == cic_pkg::host_ack_off) begin
                seen_reg <= 1'b0;
            end
            reg_rdata_out <= 8'h00;
            if (reg_rd_in) begin
                if (reg_addr_in == cic_pkg::host_status_off) begin
                    reg_rdata_out <= {5'h00, ack_st_reg != cic_pkg::cic_ack_idle,
                                      seen_reg, bus.cpu_int};
                end else if (reg_addr_in == cic_pkg::host_vector_off) begin
                    reg_rdata_out <= vec_reg;
                end
            end
        end
    end

    assign bus.io_addr   = io_addr_reg;
    assign bus.io_data   = io_data_reg;
    assign bus.io_wr     = io_wr_reg;
    assign bus.ack_cycle = ack_reg;

endmodule // cic_cpu_end

// *** cic_link_props.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// watcher on the link between cpu end and device end
// ------------------------------------------------------------
module cic_link_props (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_data,
    input wire logic       io_wr,
    input wire logic       ack_cycle,
    input wire logic       cpu_int,
    input wire logic [7:0] vector,
    input wire logic       vector_valid
);
    logic [4:0] base_reg [2];  // bases seen on the wire, primary first
    logic [1:0] due_reg;       // init word one seen, base comes next

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // follow each controller's init sequence far enough to learn its base
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            base_reg <= '{default: 5'h00};
            due_reg  <= 2'h0;
        end else if (io_wr) begin
            for (int i = 0; i < 2; i++) begin
                if (io_addr == (i ? cic_pkg::sec_even_addr : cic_pkg::prim_even_addr)
                    && io_data[cic_pkg::init_flag_bit]) begin
                    due_reg[i] <= 1'b1;
                end else if (due_reg[i] &&
                    io_addr == (i ? cic_pkg::sec_odd_addr : cic_pkg::prim_odd_addr)) begin
                    due_reg[i]  <= 1'b0;
                    base_reg[i] <= io_data[7:cic_pkg::base_lsb];
                end
            end
        end
    end

    property p_ack_seq;
        ack_cycle && !$past(ack_cycle, 2) |=> !ack_cycle ##1 ack_cycle ##1 vector_valid;
    endproperty
    a_ack_seq: assert property (p_ack_seq) else $error("ack pair out of order");
    property p_ack_gap;
        ack_cycle |=> !ack_cycle;
    endproperty
    a_ack_gap: assert property (p_ack_gap) else $error("ack pulse too long");
    property p_valid_pulse;
        vector_valid |=> !vector_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
    property p_valid_src;
        vector_valid |-> $past(ack_cycle);
    endproperty
    a_valid_src: assert property (p_valid_src) else $error("vector without ack");
    property p_vec_hold;
        !$stable(vector) |-> vector_valid;
    endproperty
    a_vec_hold: assert property (p_vec_hold) else $error("vector moved alone");
    property p_wr_pulse;
        io_wr |=> !io_wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("io write too long");
    property p_base;
        vector_valid |-> (vector[7:3] == base_reg[0] || vector[7:3] == base_reg[1]);
    endproperty
    a_base: assert property (p_base) else $error("vector base not programmed");
    property p_ack_excl;
        ack_cycle |-> !io_wr;
    endproperty
    a_ack_excl: assert property (p_ack_excl) else $error("write inside ack");

    c_vec: cover property (vector_valid);
    c_spur: cover property (vector_valid && vector[2:0] == cic_pkg::spurious_index);
    c_init: cover property (io_wr && io_data[cic_pkg::init_flag_bit]);
    c_int: cover property ($rose(cpu_int));
endmodule // cic_link_props

// *** cascaded_irq_ctrl_init_test.sv ***
`timescale 1ns/1ns
module cascaded_irq_ctrl_init_test;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic [7:0] req_primary = 8'h00;
    logic [7:0] req_secondary = 8'h00;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       cascade_mode;
    logic [7:0] rd_val;
    int         bad_count = 0;
    int         comparisons = 0;

    cic_if cic_if_inst ();
    cic_dev_end cic_dev_end_inst (.clk_in(clk_in), .rst_in(rst_in), .bus(cic_if_inst.dev),
        .req_primary_in(req_primary), .req_secondary_in(req_secondary),
        .cascade_mode_out(cascade_mode));
    cic_cpu_end cic_cpu_end_inst (.clk_in(clk_in), .rst_in(rst_in), .bus(cic_if_inst.cpu),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata));
    cic_link_props cic_link_props_inst (.clk_in(clk_in), .rst_in(rst_in),
        .io_addr(cic_if_inst.io_addr), .io_data(cic_if_inst.io_data),
        .io_wr(cic_if_inst.io_wr), .ack_cycle(cic_if_inst.ack_cycle),
        .cpu_int(cic_if_inst.cpu_int), .vector(cic_if_inst.vector),
        .vector_valid(cic_if_inst.vector_valid));

    initial forever #5 clk_in = ~clk_in;

    // ------------------------------------------------------------
    // report and compare
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // host register port, one-cycle strobes with a gap between
    // ------------------------------------------------------------
    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;  // data stands only in the cycle after the strobe
    endtask
    task automatic io_write(input logic [7:0] a, input logic [7:0] d);
        reg_write(cic_pkg::host_io_addr_off, a);
        reg_write(cic_pkg::host_io_data_off, d);
    endtask
    // link word only goes out in cascade, as the device skips it otherwise
    task automatic init_ctrl(input logic [7:0] even, w1, base, link, opts);
        io_write(even, w1);
        io_write(even + 8'h01, base);
        if (!w1[cic_pkg::single_bit])
            io_write(even + 8'h01, link);
        io_write(even + 8'h01, opts);
    endtask
    task automatic do_ack(input logic [7:0] exp, input string name);
        int n;
        reg_write(cic_pkg::host_ack_off, 8'h00);
        n = 0;
        while (cic_if_inst.vector_valid !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 20) begin
            bad_count++;
            $display("[ERR] %s expected valid seen none", name);
            print_verdict();
        end else begin
            check8(name, exp, cic_if_inst.vector);
            @(posedge clk_in);
        end
    endtask
    task automatic check_int(input logic exp, input string name);
        repeat (4) @(posedge clk_in);
        #1 check8(name, {7'h00, exp}, {7'h00, cic_if_inst.cpu_int});
    endtask
    task automatic set_req(input logic [7:0] p, input logic [7:0] s);
        @(posedge clk_in);
        req_primary   <= p;
        req_secondary <= s;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        init_ctrl(8'h20, 8'h11, 8'h08, 8'h04, 8'h01);
        init_ctrl(8'ha0, 8'h11, 8'h70, 8'h02, 8'h01);
        check8("cascade flag", 8'h01, {7'h00, cascade_mode});
        set_req(8'h08, 8'h00);
        check_int(1'b1, "int edge");
        reg_read(cic_pkg::host_status_off, rd_val);
        check8("status pending", 8'h01, rd_val);
        do_ack(8'h0b, "vec edge");
        reg_read(cic_pkg::host_vector_off, rd_val);
        check8("vec reg", 8'h0b, rd_val);
        reg_read(cic_pkg::host_status_off, rd_val);
        check8("status served", 8'h02, rd_val);
        io_write(8'h20, 8'h20);
        check_int(1'b0, "int line held");
        set_req(8'h0a, 8'h00);
        check_int(1'b1, "int early");
        set_req(8'h08, 8'h00);
        do_ack(8'h0f, "vec early drop");
        set_req(8'h00, 8'h20);
        do_ack(8'h75, "vec cascade");
        io_write(8'ha0, 8'h20);
        io_write(8'h20, 8'h20);
        // mask input four, then restart in level mode to clear it
        io_write(8'h21, 8'h10);
        set_req(8'h10, 8'h00);
        check_int(1'b0, "int masked");
        init_ctrl(8'h20, 8'h19, 8'h08, 8'h04, 8'h01);
        check_int(1'b1, "int level");
        do_ack(8'h0c, "vec level");
        io_write(8'h20, 8'h20);
        check_int(1'b1, "int level again");
        set_req(8'h00, 8'h00);
        check_int(1'b0, "int level dropped");
        // single mode with auto service done, level line kept high
        init_ctrl(8'h20, 8'h1b, 8'h20, 8'h00, 8'h03);
        check8("single flag", 8'h00, {7'h00, cascade_mode});
        set_req(8'h01, 8'h00);
        do_ack(8'h20, "vec single");
        do_ack(8'h20, "vec auto done");
        reg_read(3'h7, rd_val);
        check8("unmapped", 8'h00, rd_val);
        print_verdict();
    end
endmodule // cascaded_irq_ctrl_init_test
